// ### hw/sbd_params.svh
// Constants of the serial register-access port with burst debug
`ifndef SBD_PARAMS_SVH
`define SBD_PARAMS_SVH
`define SBD_CNT_HDR_LAST 5'd19
`define SBD_CNT_HDR_END 5'd21
`define SBD_HDR_RW 19
`define SBD_HDR_BURST 18
`define SBD_HDR_PKG_HI 14
`define SBD_HDR_PKG_LO 11
`define SBD_HDR_ADDR_HI 10
`define SBD_WBIT_FIRST 5'd0
`define SBD_WBIT_COMMIT 5'd1
`define SBD_WBIT_LAST 5'd31
`define SBD_WIDX_FIRST 11'h000
`define SBD_WIDX_STEP 11'h001
`define SBD_WIDX_56 11'h001
`define SBD_ADDR_CNTS 11'h006
`define SBD_ADDR_CHKSUM 11'h007
`define SBD_CNT_MAX 16'hffff
`define SBD_CNT_ONE 16'h0001
`endif

// ### hw/sbd_pkg.sv
// Types of the serial register-access port with burst debug
package sbd_pkg;
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_HDR  = 3'b010,
        PH_DATA = 3'b100
    } sbd_phase_t;
endpackage

// ### hw/sbd_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module sbd_sync #(
    parameter int W = 1
) (
    input wire logic mclk,          // System clock
    input wire logic rst,           // Synchronous reset, active high
    input wire logic [W-1:0] d,     // Asynchronous inputs
    output logic [W-1:0] q          // Synchronised outputs
);
    logic [W-1:0] meta_r;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge mclk) begin
                if (rst) begin
                    meta_r[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta_r[i] <= d[i];
                    q[i] <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule

// ### hw/sbd_spi_slave.sv
// Serial slave register-access port with burst mode and burst debug registers
// Operation
// - Frame: rw, burst, idle, package, address, idle, data, term
// - Leading bit one reads, zero writes
// - Burst flag selects auto-incrementing multi-word transfer
// - Idle and termination bit values are ignored
// - Package field must equal strapped package address
// - Output undriven except while returning read data
// - Read drives output from idle bits after address
// - Each further burst word targets next address
// - Commit word after two following bits arrive
// - Burst read words follow back to back
// - Debug registers clear at burst header, else change only past 56 burst bits
// - Checksum sums burst write words after first
// - Counters count address increments and clock edges
// - Reset clears all state of the port
`timescale 1ns/1ps
`include "sbd_params.svh"
module sbd_spi_slave
    import sbd_pkg::*;
(
    input wire logic mclk,                      // System clock, 50 MHz
    input wire logic rst,                       // Synchronous reset, active high
    input wire logic sclk,                      // Serial clock from master
    input wire logic cs_n,                      // Select from master, active low
    input wire logic sdi,                       // Serial data in
    output logic sdo,                           // Serial data out
    output logic sdo_oe,                        // Serial data out enable
    input wire logic [3:0] package_addr_straps, // Strapped package address
    output logic [10:0] reg_addr,               // Register address
    output logic [31:0] reg_wdata,              // Register write data
    output logic reg_we,                        // Register write strobe
    output logic reg_rd,                        // Register read strobe
    input wire logic [31:0] reg_rdata           // Register read data, next cycle
);
    // ========================================
    // Input sampling
    logic [6:0] sync_q;
    logic sclk_s, cs_n_s, sdi_s;
    logic [3:0] straps_s;
    logic sclk_d_r;

    sbd_sync #(.W(7)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .d({sclk, cs_n, sdi, package_addr_straps}),
        .q(sync_q)
    );
    assign {sclk_s, cs_n_s, sdi_s, straps_s} = sync_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
        end
    end

    logic sel, rise, fall;
    assign sel = ~cs_n_s;
    assign rise = sel & sclk_s & ~sclk_d_r;
    assign fall = sel & ~sclk_s & sclk_d_r;

    // ========================================
    // Frame sequencing
    sbd_phase_t phase_r;
    logic [4:0] cnt_r;
    logic [4:0] wbit_r;
    logic [10:0] widx_r;
    logic [18:0] hdr_sr_r;
    logic [19:0] hdr_w;
    logic rw_r, burst_r, match_r;
    logic [10:0] addr_r;

    assign hdr_w = {hdr_sr_r, sdi_s};

    always_ff @(posedge mclk) begin
        if (rst || !sel) begin
            phase_r <= PH_IDLE;
            cnt_r <= 5'h00;
            wbit_r <= `SBD_WBIT_FIRST;
            widx_r <= `SBD_WIDX_FIRST;
            hdr_sr_r <= 19'h00000;
        end else begin
            unique case (phase_r)
                PH_IDLE: begin
                    phase_r <= PH_HDR;
                end
                PH_HDR: begin
                    if (rise) begin
                        hdr_sr_r <= hdr_w[18:0];
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r == `SBD_CNT_HDR_END) begin
                            phase_r <= PH_DATA;
                        end
                    end
                end
                PH_DATA: begin
                    if (rise) begin
                        wbit_r <= wbit_r + 5'h01;
                        if (wbit_r == `SBD_WBIT_LAST) begin
                            widx_r <= widx_r + `SBD_WIDX_STEP;
                        end
                    end
                end
            endcase
        end
    end

    logic hdr_done;
    assign hdr_done = rise && (phase_r == PH_HDR) && (cnt_r == `SBD_CNT_HDR_LAST);

    // Idle bits between the fields are never looked at
    always_ff @(posedge mclk) begin
        if (rst) begin
            rw_r <= 1'b0;
            burst_r <= 1'b0;
            match_r <= 1'b0;
            addr_r <= 11'h000;
        end else if (!sel) begin
            match_r <= 1'b0;
        end else if (hdr_done) begin
            rw_r <= hdr_w[`SBD_HDR_RW];
            burst_r <= hdr_w[`SBD_HDR_BURST];
            match_r <= (hdr_w[`SBD_HDR_PKG_HI:`SBD_HDR_PKG_LO] == straps_s);
            addr_r <= hdr_w[`SBD_HDR_ADDR_HI:0];
        end
    end

    // ========================================
    // Write data path
    logic [31:0] rx_r, hold_r;
    logic [10:0] hold_addr_r;
    logic hold_v_r;
    logic in_data, word_done, commit;
    logic [31:0] rx_word;

    assign in_data = rise && (phase_r == PH_DATA);
    assign rx_word = {rx_r[30:0], sdi_s};
    assign word_done = in_data && (wbit_r == `SBD_WBIT_LAST) && match_r &&
                       (burst_r || (widx_r == `SBD_WIDX_FIRST));
    assign commit = in_data && (wbit_r == `SBD_WBIT_COMMIT) && hold_v_r;

    always_ff @(posedge mclk) begin
        if (rst || !sel) begin
            rx_r <= 32'h00000000;
            hold_r <= 32'h00000000;
            hold_addr_r <= 11'h000;
            hold_v_r <= 1'b0;
        end else begin
            if (in_data) begin
                rx_r <= rx_word;
            end
            if (word_done && !rw_r) begin
                hold_r <= rx_word;
                hold_addr_r <= addr_r + widx_r;
                hold_v_r <= 1'b1;
            end else if (commit) begin
                hold_v_r <= 1'b0;
            end
        end
    end

    // ========================================
    // Register access strobes
    logic rd_first, rd_next, rd_req, rd_pend_r;
    logic [31:0] rbuf_r;
    logic [31:0] dbg_cnts, chksum_r;

    assign rd_first = hdr_done && hdr_w[`SBD_HDR_RW] &&
                      (hdr_w[`SBD_HDR_PKG_HI:`SBD_HDR_PKG_LO] == straps_s);
    assign rd_next = in_data && (wbit_r == `SBD_WBIT_FIRST) && rw_r && burst_r && match_r;
    assign rd_req = rd_first || rd_next;

    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_addr <= 11'h000;
            reg_wdata <= 32'h00000000;
            reg_we <= 1'b0;
            reg_rd <= 1'b0;
            rd_pend_r <= 1'b0;
            rbuf_r <= 32'h00000000;
        end else begin
            reg_we <= commit;
            reg_rd <= rd_req;
            rd_pend_r <= rd_req;
            if (commit) begin
                reg_addr <= hold_addr_r;
                reg_wdata <= hold_r;
            end else if (rd_first) begin
                reg_addr <= hdr_w[`SBD_HDR_ADDR_HI:0];
            end else if (rd_next) begin
                reg_addr <= addr_r + widx_r + `SBD_WIDX_STEP;
            end
            if (rd_pend_r) begin
                if (reg_addr == `SBD_ADDR_CNTS) begin
                    rbuf_r <= dbg_cnts;
                end else if (reg_addr == `SBD_ADDR_CHKSUM) begin
                    rbuf_r <= chksum_r;
                end else begin
                    rbuf_r <= reg_rdata;
                end
            end
        end
    end

    // ========================================
    // Burst debug registers
    logic [15:0] inc_cnt_r, edge_cnt_r;
    logic past56_r;
    logic burst_act;

    assign burst_act = burst_r && match_r;
    assign dbg_cnts = {inc_cnt_r, edge_cnt_r};

    always_ff @(posedge mclk) begin
        if (rst) begin
            inc_cnt_r <= 16'h0000;
            edge_cnt_r <= 16'h0000;
            chksum_r <= 32'h00000000;
            past56_r <= 1'b0;
        end else begin
            if (!sel) begin
                past56_r <= 1'b0;
            end else if (in_data && (widx_r == `SBD_WIDX_56) &&
                         (wbit_r == `SBD_WBIT_COMMIT)) begin
                past56_r <= 1'b1;
            end
            if (hdr_done && hdr_w[`SBD_HDR_BURST] &&
                (hdr_w[`SBD_HDR_PKG_HI:`SBD_HDR_PKG_LO] == straps_s)) begin
                inc_cnt_r <= 16'h0000;
                edge_cnt_r <= 16'h0000;
                chksum_r <= 32'h00000000;
            end else begin
                if (rise && past56_r && burst_act && (edge_cnt_r != `SBD_CNT_MAX)) begin
                    edge_cnt_r <= edge_cnt_r + `SBD_CNT_ONE;
                end
                if (word_done && burst_act && (widx_r != `SBD_WIDX_FIRST)) begin
                    if (inc_cnt_r != `SBD_CNT_MAX) begin
                        inc_cnt_r <= inc_cnt_r + `SBD_CNT_ONE;
                    end
                    if (!rw_r) begin
                        chksum_r <= chksum_r + rx_word;
                    end
                end
            end
        end
    end

    // ========================================
    // Serial output
    logic [31:0] tx_r;

    always_ff @(posedge mclk) begin
        if (rst || !sel) begin
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
            tx_r <= 32'h00000000;
        end else if (rd_first) begin
            sdo_oe <= 1'b1;
        end else if (fall && sdo_oe) begin
            if ((phase_r == PH_DATA) && (wbit_r == `SBD_WBIT_FIRST) &&
                (burst_r || (widx_r == `SBD_WIDX_FIRST))) begin
                sdo <= rbuf_r[31];
                tx_r <= {rbuf_r[30:0], 1'b0};
            end else if ((phase_r == PH_DATA) && !burst_r &&
                         (widx_r != `SBD_WIDX_FIRST)) begin
                sdo_oe <= 1'b0;
                sdo <= 1'b0;
            end else begin
                sdo <= tx_r[31];
                tx_r <= {tx_r[30:0], 1'b0};
            end
        end
    end
endmodule

// ### test/sbd_spi_slave_props.sv
// Checker of the serial register-access port
`timescale 1ns/1ps
module sbd_spi_slave_props (
    input wire logic mclk, // System clock
    input wire logic rst, // Reset
    input wire logic sclk, // Serial clock
    input wire logic cs_n, // Select
    input wire logic sdi, // Serial data in
    input wire logic sdo, // Serial data out
    input wire logic sdo_oe, // Output enable
    input wire logic [3:0] package_addr_straps, // Straps
    input wire logic [10:0] reg_addr, // Address
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_we, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [31:0] reg_rdata // Read data
);
    // ====
    // Properties
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_we_one_cycle: assert property (reg_we |=> !reg_we)
        else $error("write strobe longer than one cycle");
    a_rd_one_cycle: assert property (reg_rd |=> !reg_rd)
        else $error("read strobe longer than one cycle");
    a_oe_with_read: assert property ($rose(sdo_oe) |-> reg_rd)
        else $error("output enabled without a read");
    a_oe_desel_off: assert property (cs_n [*8] |-> !sdo_oe)
        else $error("output driven while deselected");
    a_desel_quiet: assert property (cs_n [*8] |-> !reg_we && !reg_rd)
        else $error("access while deselected");
    a_no_oe_write: assert property (sdo_oe |-> !reg_we)
        else $error("output driven during a write");
    a_addr_holds: assert property ($changed(reg_addr) |-> reg_we || reg_rd)
        else $error("address moved without access");
    a_wdata_holds: assert property ($changed(reg_wdata) |-> reg_we || reg_rd)
        else $error("write data moved without access");
    a_rw_exclusive: assert property (!(reg_we && reg_rd))
        else $error("read and write strobes together");
endmodule
bind sbd_spi_slave sbd_spi_slave_props u_props (.*);

// ### test/sbd_master.sv
// Serial master model that drives frames into the port
`timescale 1ns/1ps
module sbd_master (
    output logic sclk, // Serial clock
    output logic cs_n, // Select, active low
    output logic sdi, // Serial data toward port
    input wire logic sdo, // Serial data from port
    input wire logic sdo_oe // Port output enable
);
    logic [31:0] wd [8];
    logic [31:0] rd [8];
    int oe_err;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        oe_err = 0;
    end
    // ====
    // Frame
    task automatic frame(input logic rw, input logic bst, input logic [3:0] pkg,
                         input logic [10:0] adr, input int nw, input int nt);
        logic [21:0] hdr;
        int nb;
        int k;
        hdr = {rw, bst, 3'h7, pkg, adr, 2'h3};
        nb = 22 + 32 * nw + nt;
        cs_n = 1'b0;
        #80;
        for (int n = 0; n < nb; n++) begin
            k = (n - 22) / 32;
            if (n < 22 && !(rw && n >= 20))
                sdi = hdr[21 - n];
            else if (n >= 22 && k < nw && !rw)
                sdi = wd[k][31 - (n - 22) % 32];
            else
                sdi = ~sdi;
            #80 sclk = 1'b1;
            #78;
            if (n >= 22 && k < nw) begin
                if (sdo_oe !== rw)
                    oe_err++;
                rd[k] = {rd[k][30:0], sdo};
            end
            #2 sclk = 1'b0;
        end
        #80 cs_n = 1'b1;
        sdi = ~sdi;
        #300;
    endtask
endmodule

// ### test/sbd_spi_slave_bench.sv
// Self-checking bench of the serial register-access port
`timescale 1ns/1ps
module sbd_spi_slave_bench;
    logic mclk, rst, sclk, cs_n, sdi, sdo, sdo_oe, reg_we, reg_rd;
    logic [3:0] package_addr_straps;
    logic [10:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [42:0] wlog [$];
    int mismatches, n_tests, cyc;
    sbd_spi_slave dut (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .package_addr_straps(package_addr_straps),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    sbd_master m (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
    always #10 mclk = ~mclk;
    function automatic logic [31:0] rd_val(input logic [10:0] a);
        return {21'h0, a} ^ 32'h5a5a0000;
    endfunction
    // ====
    // Register file stand-in and timeout
    always @(posedge mclk) begin
        if (reg_we === 1'b1)
            wlog.push_back({reg_addr, reg_wdata});
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            test_done();
        end
    end
    // Read data follows the address just launched, ready for the next edge
    always @(posedge mclk) begin
        #1 reg_rdata <= rd_val(reg_addr);
    end
    task automatic chk(input string what, input logic [42:0] exp, input logic [42:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wchk(input logic [10:0] a, input logic [31:0] d);
        chk("write", {a, d}, (wlog.size() > 0) ? wlog.pop_front() : 43'hx);
    endtask
    task automatic test_done();
        if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ====
    // Sequence
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        package_addr_straps = 4'h5;
        reg_rdata = 32'h0;
        mismatches = 0;
        n_tests = 0;
        cyc = 0;
        repeat (8) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (8) @(posedge mclk);
        #1;
        m.wd[0] = 32'hdeadbeef;
        m.frame(1'b0, 1'b0, 4'h5, 11'h123, 1, 2);
        wchk(11'h123, 32'hdeadbeef);
        m.frame(1'b0, 1'b0, 4'h6, 11'h124, 1, 2);
        chk("writes", 43'h0, 43'(wlog.size()));
        m.frame(1'b1, 1'b0, 4'h5, 11'h045, 1, 2);
        chk("rdata", {11'h0, rd_val(11'h045)}, {11'h0, m.rd[0]});
        m.wd[1] = 32'hf6501100;
        m.wd[2] = 32'hf010f600;
        m.wd[3] = 32'hcc010000;
        m.wd[4] = 32'hbc000012;
        m.frame(1'b0, 1'b1, 4'h5, 11'h7fe, 5, 1);
        for (int k = 0; k < 4; k++)
            wchk(11'h7fe + 11'(k), m.wd[k]);
        chk("writes", 43'h0, 43'(wlog.size()));
        m.frame(1'b1, 1'b0, 4'h5, 11'h007, 1, 2);
        chk("checksum", {11'h0, 32'h6e620712}, {11'h0, m.rd[0]});
        m.frame(1'b1, 1'b0, 4'h5, 11'h006, 1, 2);
        chk("counters", {11'h0, 32'h0004007f}, {11'h0, m.rd[0]});
        m.frame(1'b1, 1'b1, 4'h5, 11'h010, 3, 2);
        for (int k = 0; k < 3; k++)
            chk("burst", {11'h0, rd_val(11'h010 + 11'(k))}, {11'h0, m.rd[k]});
        m.frame(1'b1, 1'b0, 4'h5, 11'h006, 1, 2);
        chk("counters", {11'h0, 32'h00020040}, {11'h0, m.rd[0]});
        chk("oe errors", 43'h0, 43'(m.oe_err));
        test_done();
    end
endmodule
